//--- design/scc_top.sv
// Operation
// RULE1 - sixteen channels, one-cycle resolution, eight cycles when staggered
// RULE2 - two independent 16-bit timers, each with its own reload register
// RULE3 - timer clock from prescaled system clock or aux timer overflow
// RULE4 - timers may count pulses on external count inputs
// RULE5 - each channel picks either timer and capture or compare
// RULE6 - one pin per channel: capture trigger input or compare output
// RULE7 - capture edge stores the assigned timer value into the channel
// RULE8 - every capture raises the channel's own interrupt request
// RULE9 - capture edge selectable: rising, falling or both
// RULE10 - compare channels match continuously against their assigned timer
// RULE11 - mode 0: interrupt only, every match reported
// RULE12 - mode 1: pin toggles on every match
// RULE13 - mode 2: interrupt only, at most one per timer period
// RULE14 - mode 3: pin high on match, low on overflow, once per period
// RULE15 - double register: two channels toggle one shared pin
// RULE16 - single-event option stops a compare channel after one event
// RULE17 - on overflow a timer loads its reload value and counts on
// RULE18 - interrupt-mode compare match sets the channel's request flag
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ps
module scc_top (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     ce,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [scc_pkg::AW-1:0]   paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic [scc_pkg::NCH-1:0]  pin_in,
  output logic      [scc_pkg::NCH-1:0]  pin_out,
  output logic      [scc_pkg::NCH-1:0]  pin_oe,
  input  wire logic [1:0]               cnt_in,
  input  wire logic                     aux_ovf,
  output logic                          irq
);
  import scc_pkg::*;

  typedef struct packed {
    logic [CTRL_W-1:0]          ctrl;
    logic [1:0][TW-1:0]         reload;
    logic [1:0][TW-1:0]         timer;
    logic [NCH-1:0]             status;
    logic [NCH-1:0]             mask;
    logic [NCH-1:0][MR_W-1:0]   mode;
    logic [NCH-1:0]             pdone;
    logic [NCH-1:0]             sdone;
    logic [NSYNC-1:0]           sync1;
    logic [NSYNC-1:0]           sync2;
    logic [NSYNC-1:0]           sync3;
    logic [NSYNC-1:0]           lvl;
    logic [PRESC_W-1:0]         presc;
    logic [NCH-1:0]             pin_out;
    logic [NCH-1:0]             pin_oe;
    logic [31:0]                prdata;
    logic                       pready;
    logic                       pslverr;
    logic                       irq;
  } scc_state_type;

  scc_state_type        st;
  scc_state_type        next_st;
  logic [1:0]           tick;
  logic [1:0]           ovf;
  logic [1:0][TW-1:0]   nt;
  logic [NSYNC-1:0]     rise;
  logic [NSYNC-1:0]     fall;
  logic [NCH-1:0]       cap_ev;
  logic [NCH-1:0]       match;
  logic [NCH-1:0]       tog;
  logic [NCH-1:0]       irq_ev;
  logic [NCH-1:0]       ev;
  logic [NCH-1:0]       cap_we;
  logic [NCH*TW-1:0]    cap_data;
  logic [NCH*TW-1:0]    words;
  logic [TW-1:0]        mem_rdata;
  logic                 mem_we;
  logic                 acc_done;
  logic                 wr;
  logic [3:0]           idx;

  // =====================================================================
  // decoders
  function automatic logic tick_sel(input logic [2:0] cks,
                                    input logic [PRESC_W-1:0] p,
                                    input logic aux,
                                    input logic ext);
    case (cks)
      CKS_SYS:    tick_sel = 1'b1;
      CKS_DIV8:   tick_sel = &p[2:0];
      CKS_DIV64:  tick_sel = &p[5:0];
      CKS_DIV512: tick_sel = &p;
      CKS_AUX:    tick_sel = aux;
      CKS_EXT:    tick_sel = ext;
      default:    tick_sel = 1'b0;
    endcase
  endfunction : tick_sel

  function automatic logic addr_ok(input logic [AW-1:0] a);
    case (a)
      OFF_CTRL, OFF_RELOAD0, OFF_RELOAD1, OFF_TIMER0, OFF_TIMER1,
      OFF_STATUS, OFF_MASK, OFF_PINS: addr_ok = 1'b1;
      default: addr_ok = (a[7:6] == REGION_MODE ||
                          a[7:6] == REGION_VALUE) && a[1:0] == 2'h0;
    endcase
  endfunction : addr_ok

  // =====================================================================
  // channel value storage
  scc_value_mem #(.N(NCH), .W(TW)) u_mem (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .cpu_we    (mem_we),
    .cpu_addr  (idx),
    .cpu_wdata (pwdata[TW-1:0]),
    .cap_we    (cap_we),
    .cap_data  (cap_data),
    .rdata     (mem_rdata),
    .words     (words)
  );

  // =====================================================================
  // next state
  always_comb begin
    logic [2:0] md;
    logic       ts;
    logic       once;
    md       = '0;
    ts       = 1'b0;
    once     = 1'b0;
    next_st  = st;
    tick     = '0;
    ovf      = '0;
    nt       = st.timer;
    rise     = '0;
    fall     = '0;
    cap_ev   = '0;
    match    = '0;
    tog      = '0;
    irq_ev   = '0;
    ev       = '0;
    cap_we   = '0;
    cap_data = '0;
    mem_we   = 1'b0;
    idx      = paddr[5:2];
    acc_done = psel && penable && st.pready;
    wr       = acc_done && pwrite && addr_ok(paddr);
    if (ce) begin
      next_st.presc = st.presc + 1'b1;
      // three-stage pin sync; a change counts when stages 2 and 3 agree
      next_st.sync1 = {cnt_in, pin_in};
      next_st.sync2 = st.sync1;
      next_st.sync3 = st.sync2;
      for (int b = 0; b < NSYNC; b++) begin
        if (st.sync2[b] == st.sync3[b]) begin
          next_st.lvl[b] = st.sync3[b];
        end
        rise[b] = st.sync2[b] && st.sync3[b] && !st.lvl[b];
        fall[b] = !st.sync2[b] && !st.sync3[b] && st.lvl[b];
      end
      // timers; staggered mode only ticks on one slot of eight
      for (int t = 0; t < 2; t++) begin
        tick[t] = st.ctrl[CTRL_RUN0 + t] &&
                  tick_sel(st.ctrl[CTRL_CKS0 + 3*t +: 3], st.presc,
                           aux_ovf, rise[NCH + t]) &&     // see RULE3 RULE4
                  (!st.ctrl[CTRL_STAGGER] ||
                   st.presc[2:0] == STAGGER_SLOT);        // see RULE1
        if (tick[t]) begin
          if (st.timer[t] == TIMER_MAX) begin
            ovf[t] = 1'b1;
            nt[t]  = st.reload[t];                        // see RULE17
          end else begin
            nt[t]  = st.timer[t] + 16'h0001;              // see RULE2
          end
        end
      end
      next_st.timer = nt;
      // per-channel capture and compare
      for (int i = 0; i < NCH; i++) begin
        md   = st.mode[i][2:0];
        ts   = st.mode[i][MR_TSEL];                       // see RULE5
        once = (md == MD_CMP2 || md == MD_CMP3);
        case (md)
          MD_CAP_RISE: cap_ev[i] = rise[i];               // see RULE9
          MD_CAP_FALL: cap_ev[i] = fall[i];
          MD_CAP_BOTH: cap_ev[i] = rise[i] || fall[i];
          default:     cap_ev[i] = 1'b0;
        endcase
        if (cap_ev[i]) begin
          cap_we[i] = 1'b1;
          cap_data[i*TW +: TW] = st.timer[ts];            // see RULE7
        end
        match[i] = md[2] && tick[ts] &&
                   words[i*TW +: TW] == nt[ts];           // see RULE10
        ev[i] = match[i] && !st.sdone[i] &&
                !(once && st.pdone[i] && !ovf[ts]);
        if (ovf[ts]) begin
          next_st.pdone[i] = 1'b0;
        end
        case (md)
          MD_CMP0: irq_ev[i] = ev[i];                     // see RULE11
          MD_CMP1: tog[i]    = ev[i];                     // see RULE12
          MD_CMP2: irq_ev[i] = ev[i];                     // see RULE13
          default: irq_ev[i] = 1'b0;
        endcase
        if (ev[i] && once) begin
          next_st.pdone[i] = 1'b1;
        end
        if (md == MD_CMP3) begin
          if (ev[i]) begin
            next_st.pin_out[i] = 1'b1;                    // see RULE14
          end else if (ovf[ts]) begin
            next_st.pin_out[i] = 1'b0;                    // see RULE14
          end
        end
        if (ev[i] && st.mode[i][MR_SINGLE]) begin
          next_st.sdone[i] = 1'b1;                        // see RULE16
        end
        next_st.pin_oe[i] = (md == MD_CMP1 || md == MD_CMP3); // see RULE6
      end
      // upper half of the array may drive the lower pins as a pair
      for (int i = 0; i < NCH/2; i++) begin
        if (st.mode[i][MR_DBL] && ev[i + NCH/2]) begin
          tog[i] = 1'b1;                                  // see RULE15
        end
      end
      for (int i = 0; i < NCH; i++) begin
        if (tog[i]) begin
          next_st.pin_out[i] = !st.pin_out[i];
        end
      end
      // sticky flags; a new event beats the read that clears it
      next_st.status = (st.status &
                        ~((acc_done && !pwrite && paddr == OFF_STATUS) ?
                          st.prdata[NCH-1:0] : {NCH{1'b0}})) |
                       cap_ev | irq_ev;                   // see RULE8 RULE18
      // apb: one wait state so the value memory read can settle
      next_st.pready = psel && penable && !st.pready;
      if (psel && penable && !st.pready) begin
        next_st.pslverr = !addr_ok(paddr);
        case (paddr)
          OFF_CTRL:    next_st.prdata = {23'h0, st.ctrl};
          OFF_RELOAD0: next_st.prdata = {16'h0, st.reload[0]};
          OFF_RELOAD1: next_st.prdata = {16'h0, st.reload[1]};
          OFF_TIMER0:  next_st.prdata = {16'h0, st.timer[0]};
          OFF_TIMER1:  next_st.prdata = {16'h0, st.timer[1]};
          OFF_STATUS:  next_st.prdata = {16'h0, st.status};
          OFF_MASK:    next_st.prdata = {16'h0, st.mask};
          OFF_PINS:    next_st.prdata = {st.lvl[NCH-1:0], st.pin_out};
          default: begin
            if (!addr_ok(paddr)) begin
              next_st.prdata = 32'h0;
            end else if (paddr[7:6] == REGION_MODE) begin
              next_st.prdata = {26'h0, st.mode[idx]};
            end else begin
              next_st.prdata = {16'h0, mem_rdata};
            end
          end
        endcase
      end
      if (wr) begin
        case (paddr)
          OFF_CTRL:    next_st.ctrl      = pwdata[CTRL_W-1:0];
          OFF_RELOAD0: next_st.reload[0] = pwdata[TW-1:0];
          OFF_RELOAD1: next_st.reload[1] = pwdata[TW-1:0];
          OFF_TIMER0:  next_st.timer[0]  = pwdata[TW-1:0];
          OFF_TIMER1:  next_st.timer[1]  = pwdata[TW-1:0];
          OFF_MASK:    next_st.mask      = pwdata[NCH-1:0];
          default: begin
            if (paddr[7:6] == REGION_MODE) begin
              next_st.mode[idx]  = pwdata[MR_W-1:0];
              next_st.sdone[idx] = 1'b0;
              next_st.pdone[idx] = 1'b0;
            end else if (paddr[7:6] == REGION_VALUE) begin
              mem_we = 1'b1;
            end
          end
        endcase
      end
      next_st.irq = |(next_st.status & next_st.mask);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st        <= '0;
      st.ctrl   <= CTRL_RST;
      st.reload <= {RELOAD_RST, RELOAD_RST};
      st.timer  <= {TIMER_RST, TIMER_RST};
      st.mask   <= MASK_RST;
      st.mode   <= {NCH{MODE_RST}};
    end else begin
      st <= next_st;
    end
  end

  assign prdata  = st.prdata;
  assign pready  = st.pready;
  assign pslverr = st.pslverr;
  assign pin_out = st.pin_out;
  assign pin_oe  = st.pin_oe;
  assign irq     = st.irq;

  // =====================================================================
  // checks
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_reload;
    tick[0] && st.timer[0] == TIMER_MAX && !(wr && paddr == OFF_TIMER0)
      |=> st.timer[0] == $past(st.reload[0]);
  endproperty
  a_reload: assert property (p_reload) else $error("no reload"); // see RULE17

  property p_count;
    tick[1] && st.timer[1] != TIMER_MAX && !(wr && paddr == OFF_TIMER1)
      |=> st.timer[1] == $past(st.timer[1]) + 16'h0001;
  endproperty
  a_count: assert property (p_count) else $error("bad count"); // see RULE2

  property p_stagger;
    st.ctrl[CTRL_STAGGER] && tick[0] |-> st.presc[2:0] == STAGGER_SLOT;
  endproperty
  a_stagger: assert property (p_stagger) else $error("tick off slot"); // see RULE1

  property p_capture;
    cap_ev[0] && !(wr && paddr == 8'h80)
      |=> words[TW-1:0] == $past(st.timer[st.mode[0][MR_TSEL]]);
  endproperty
  a_capture: assert property (p_capture) else $error("bad capture"); // see RULE7

  property p_cap_flag;
    cap_ev[0] |=> st.status[0] && (st.irq || !st.mask[0]);
  endproperty
  a_cap_flag: assert property (p_cap_flag) else $error("flag lost"); // see RULE8

  property p_toggle;
    tog[3] |=> st.pin_out[3] != $past(st.pin_out[3]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("no toggle"); // see RULE12

  property p_once;
    st.mode[9][2:0] == MD_CMP2 && st.pdone[9] && !ovf[st.mode[9][MR_TSEL]]
      |-> !irq_ev[9];
  endproperty
  a_once: assert property (p_once) else $error("second irq"); // see RULE13

  property p_single;
    st.sdone[6] |-> !ev[6] && !tog[6];
  endproperty
  a_single: assert property (p_single) else $error("repeat event"); // see RULE16

  property p_mode3;
    st.mode[4][2:0] == MD_CMP3 && ev[4] |=> st.pin_out[4] ##0 st.pdone[4];
  endproperty
  a_mode3: assert property (p_mode3) else $error("mode3 pin"); // see RULE14
endmodule : scc_top

//--- design/scc_pkg.sv
package scc_pkg;
  // =====================================================================
  // sizes
  localparam int NCH     = 16;
  localparam int TW      = 16;
  localparam int AW      = 8;
  localparam int PRESC_W = 9;
  localparam int MR_W    = 6;
  localparam int CTRL_W  = 9;
  localparam int NSYNC   = NCH + 2;

  // =====================================================================
  // register offsets (byte addresses)
  localparam logic [AW-1:0] OFF_CTRL    = 8'h00;
  localparam logic [AW-1:0] OFF_RELOAD0 = 8'h04;
  localparam logic [AW-1:0] OFF_RELOAD1 = 8'h08;
  localparam logic [AW-1:0] OFF_TIMER0  = 8'h0c;
  localparam logic [AW-1:0] OFF_TIMER1  = 8'h10;
  localparam logic [AW-1:0] OFF_STATUS  = 8'h14;
  localparam logic [AW-1:0] OFF_MASK    = 8'h18;
  localparam logic [AW-1:0] OFF_PINS    = 8'h1c;
  localparam logic [1:0]    REGION_MODE  = 2'h1;
  localparam logic [1:0]    REGION_VALUE = 2'h2;

  // =====================================================================
  // control register fields
  localparam int CTRL_RUN0     = 0;
  localparam int CTRL_RUN1     = 1;
  localparam int CTRL_CKS0     = 2;
  localparam int CTRL_CKS1     = 5;
  localparam int CTRL_STAGGER  = 8;

  // channel mode register fields
  localparam int MR_TSEL   = 3;
  localparam int MR_SINGLE = 4;
  localparam int MR_DBL    = 5;

  // channel modes
  localparam logic [2:0] MD_OFF      = 3'h0;
  localparam logic [2:0] MD_CAP_RISE = 3'h1;
  localparam logic [2:0] MD_CAP_FALL = 3'h2;
  localparam logic [2:0] MD_CAP_BOTH = 3'h3;
  localparam logic [2:0] MD_CMP0     = 3'h4;
  localparam logic [2:0] MD_CMP1     = 3'h5;
  localparam logic [2:0] MD_CMP2     = 3'h6;
  localparam logic [2:0] MD_CMP3     = 3'h7;

  // timer count clock selects
  localparam logic [2:0] CKS_SYS    = 3'h0;
  localparam logic [2:0] CKS_DIV8   = 3'h1;
  localparam logic [2:0] CKS_DIV64  = 3'h2;
  localparam logic [2:0] CKS_DIV512 = 3'h3;
  localparam logic [2:0] CKS_AUX    = 3'h4;
  localparam logic [2:0] CKS_EXT    = 3'h5;

  // =====================================================================
  // counts and reset values
  localparam logic [2:0]        STAGGER_SLOT = 3'h7;
  localparam logic [TW-1:0]     TIMER_MAX    = 16'hffff;
  localparam logic [CTRL_W-1:0] CTRL_RST     = 9'h000;
  localparam logic [TW-1:0]     RELOAD_RST   = 16'h0000;
  localparam logic [TW-1:0]     TIMER_RST    = 16'h0000;
  localparam logic [TW-1:0]     MASK_RST     = 16'h0000;
  localparam logic [MR_W-1:0]   MODE_RST     = 6'h00;
endpackage : scc_pkg

//--- design/scc_value_mem.sv
`timescale 1ns/1ps
module scc_value_mem #(
  parameter int N = 16,
  parameter int W = 16
) (
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic           ce,
  input  wire logic           cpu_we,
  input  wire logic [3:0]     cpu_addr,
  input  wire logic [W-1:0]   cpu_wdata,
  input  wire logic [N-1:0]   cap_we,
  input  wire logic [N*W-1:0] cap_data,
  output logic      [W-1:0]   rdata,
  output logic      [N*W-1:0] words
);
  typedef struct packed {
    logic [N-1:0][W-1:0] word;
    logic [W-1:0]        rdata;
  } scc_mem_state_type;

  scc_mem_state_type st;
  scc_mem_state_type next_st;

  // =====================================================================
  // capture beats a software write to the same word
  always_comb begin
    next_st = st;
    if (ce) begin
      next_st.rdata = st.word[cpu_addr];
      if (cpu_we) begin
        next_st.word[cpu_addr] = cpu_wdata;
      end
      for (int i = 0; i < N; i++) begin
        if (cap_we[i]) begin
          next_st.word[i] = cap_data[i*W +: W];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign words = st.word;
endmodule : scc_value_mem

//--- tb/scc_pin_model.sv
`timescale 1ns/1ps
module scc_pin_model (
  input  wire logic                    pclk,
  input  wire logic [scc_pkg::NCH-1:0] pin_out,
  input  wire logic [scc_pkg::NCH-1:0] pin_oe,
  output logic      [scc_pkg::NCH-1:0] pin_in,
  output logic      [1:0]              cnt_in
);
  import scc_pkg::*;
  // ==========================================================
  // far-side levels
  logic [NCH-1:0] ext_lvl;
  initial begin
    ext_lvl = 16'h0000;
    cnt_in  = 2'h0;
  end
  // a driven pin reads back the block's own level, never a stale one
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
  // ==========================================================
  // stimulus tasks
  task automatic set_pin(input int ch, input logic v);
    @(posedge pclk);
    ext_lvl[ch] <= v;
  endtask : set_pin
  // long pulses so the synchroniser cannot miss them
  task automatic pulse_cnt(input int t);
    @(posedge pclk);
    cnt_in[t] <= 1'b1;
    repeat (4) @(posedge pclk);
    cnt_in[t] <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : pulse_cnt
endmodule : scc_pin_model

//--- tb/sixteen_channel_capture_compare_tb_top.sv
`timescale 1ns/1ps
module sixteen_channel_capture_compare_tb_top;
  import scc_pkg::*;
  // ==========================================================
  // signals
  logic           pclk, presetn, psel, penable, pwrite, aux_ovf, irq, ce;
  logic           pready, pslverr;
  logic [AW-1:0]  paddr;
  logic [31:0]    pwdata, prdata;
  logic [NCH-1:0] pin_in, pin_out, pin_oe;
  logic [1:0]     cnt_in;
  int             n_errors, checks;

  scc_top u_scc_top (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .cnt_in(cnt_in), .aux_ovf(aux_ovf), .irq(irq));
  scc_pin_model u_scc_pin_model (.pclk(pclk), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_in(pin_in), .cnt_in(cnt_in));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // ==========================================================
  // helpers
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, exp, input string what);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [AW-1:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      n_errors++;
      $display("[FAIL] %0t no pready", $time);
      tally_and_finish();
    end
  endtask : apb

  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [AW-1:0] a, input logic [31:0] x,
                    input string what);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x, what);
  endtask : rd

  function automatic logic [AW-1:0] ma(input int i);
    return 8'(8'h40 + 4 * i);
  endfunction : ma

  function automatic logic [AW-1:0] va(input int i);
    return 8'(8'h80 + 4 * i);
  endfunction : va

  function automatic logic [31:0] ctl(input logic r0, r1,
                                      input logic [2:0] c0, c1);
    return {23'h0, 1'b0, c1, c0, r1, r0};
  endfunction : ctl

  task automatic cfg(input int ch, input logic [2:0] md, input logic t,
                     s, d, input logic [15:0] v);
    wr(va(ch), {16'h0, v});
    wr(ma(ch), {26'h0, d, s, t, md});
  endtask : cfg

  task automatic wait_lvl(input int ch, input logic v, input int lim,
                          output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pin_out[ch] !== v && n < lim);
  endtask : wait_lvl

  task automatic pin_ev(input int ch, input logic v);
    u_scc_pin_model.set_pin(ch, v);
    repeat (8) @(posedge pclk);
  endtask : pin_ev
  // ==========================================================
  // scenarios
  task automatic t_reset();
    logic [31:0] r;
    logic        e;
    chk({16'h0, pin_oe}, 32'h0, "oe reset");
    rd(OFF_CTRL, {23'h0, CTRL_RST}, "ctrl reset");
    rd(OFF_RELOAD0, {16'h0, RELOAD_RST}, "reload reset");
    rd(OFF_TIMER1, {16'h0, TIMER_RST}, "timer reset");
    rd(OFF_MASK, {16'h0, MASK_RST}, "mask reset");
    rd(ma(9), {26'h0, MODE_RST}, "mode reset");
    apb(1'b0, 8'h20, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1, "unmapped read");
  endtask : t_reset

  task automatic t_capture();
    wr(OFF_TIMER0, 32'h1234);
    wr(OFF_TIMER1, 32'h5678);
    wr(OFF_MASK, 32'h1);
    cfg(0, MD_CAP_RISE, 1'b0, 1'b0, 1'b0, 16'h0000);
    cfg(1, MD_CAP_FALL, 1'b1, 1'b0, 1'b0, 16'haaaa);
    cfg(2, MD_CAP_BOTH, 1'b0, 1'b0, 1'b0, 16'h0000);
    pin_ev(0, 1'b1);
    chk({31'h0, irq}, 32'h1, "irq on capture");
    rd(va(0), 32'h1234, "rise capture");
    wr(OFF_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0, "irq masked");
    rd(OFF_STATUS, 32'h1, "capture status");
    rd(OFF_STATUS, 32'h0, "status cleared");
    pin_ev(1, 1'b1);
    rd(va(1), 32'haaaa, "fall ch ignores rise");
    pin_ev(1, 1'b0);
    rd(va(1), 32'h5678, "fall capture timer1");
    pin_ev(2, 1'b1);
    rd(OFF_STATUS, 32'h6, "both status");
    wr(OFF_TIMER0, 32'h0042);
    pin_ev(2, 1'b0);
    rd(va(2), 32'h0042, "both falling");
    rd(OFF_STATUS, 32'h4, "both again");
  endtask : t_capture

  task automatic t_compare();
    int n;
    wr(OFF_RELOAD0, 32'hfff0);
    wr(OFF_TIMER0, 32'hfff0);
    cfg(3, MD_CMP1, 1'b0, 1'b0, 1'b0, 16'hfff5);
    cfg(4, MD_CMP3, 1'b0, 1'b0, 1'b0, 16'hfff8);
    cfg(5, MD_CMP0, 1'b0, 1'b0, 1'b0, 16'hfff4);
    cfg(6, MD_CMP1, 1'b0, 1'b1, 1'b0, 16'hfff3);
    cfg(7, MD_CMP1, 1'b0, 1'b0, 1'b1, 16'hfff2);
    cfg(15, MD_CMP1, 1'b0, 1'b0, 1'b0, 16'hfffa);
    wr(OFF_CTRL, ctl(1'b1, 1'b0, CKS_SYS, CKS_SYS));
    chk({30'h0, pin_oe[5], pin_oe[3]}, 32'h1, "oe by mode");
    wait_lvl(3, ~pin_out[3], 40, n);
    wait_lvl(3, ~pin_out[3], 40, n);
    chk(n, 16, "toggle period");
    wait_lvl(4, 1'b1, 40, n);
    wait_lvl(4, 1'b0, 40, n);
    chk(n, 8, "set to overflow");
    wait_lvl(7, ~pin_out[7], 40, n);
    wait_lvl(7, ~pin_out[7], 40, n);
    chk(n, 8, "double toggle");
    wait_lvl(6, ~pin_out[6], 40, n);
    chk(n, 40, "single event stops");
    rd(OFF_RELOAD0, 32'hfff0, "reload kept");
    rd(OFF_STATUS, 32'h20, "mode0 status");
    repeat (20) @(posedge pclk);
    rd(OFF_STATUS, 32'h20, "mode0 again");
  endtask : t_compare

  // sixteen ticks per toggle of channel 3, so the period shows the tick rate
  task automatic t_prescale();
    int n;
    wr(OFF_CTRL, ctl(1'b1, 1'b0, CKS_DIV8, CKS_SYS));
    wait_lvl(3, ~pin_out[3], 300, n);
    wait_lvl(3, ~pin_out[3], 300, n);
    chk(n, 128, "div8 period");
    wr(OFF_CTRL, ctl(1'b1, 1'b0, CKS_SYS, CKS_SYS) | 32'h100);
    wait_lvl(3, ~pin_out[3], 300, n);
    wait_lvl(3, ~pin_out[3], 300, n);
    chk(n, 128, "stagger period");
    wr(OFF_CTRL, ctl(1'b1, 1'b0, CKS_DIV64, CKS_SYS));
    wait_lvl(3, ~pin_out[3], 2100, n);
    wait_lvl(3, ~pin_out[3], 2100, n);
    chk(n, 1024, "div64 period");
  endtask : t_prescale

  task automatic t_clock_src();
    logic [31:0] r;
    logic        e;
    wr(OFF_CTRL, ctl(1'b0, 1'b1, CKS_SYS, CKS_AUX));
    wr(OFF_TIMER1, 32'h0100);
    cfg(9, MD_CMP2, 1'b1, 1'b0, 1'b0, 16'h0101);
    apb(1'b0, OFF_STATUS, 32'h0, r, e);
    repeat (3) begin
      @(posedge pclk);
      aux_ovf <= 1'b1;
      @(posedge pclk);
      aux_ovf <= 1'b0;
      repeat (3) @(posedge pclk);
    end
    // a pulse while the enable is low must not count
    @(posedge pclk);
    ce <= 1'b0;
    aux_ovf <= 1'b1;
    @(posedge pclk);
    ce <= 1'b1;
    aux_ovf <= 1'b0;
    rd(OFF_TIMER1, 32'h0103, "aux clocked");
    rd(OFF_STATUS, 32'h200, "mode2 irq");
    wr(OFF_CTRL, ctl(1'b0, 1'b1, CKS_SYS, CKS_EXT));
    // rewind without overflow: the second match stays silent
    wr(OFF_TIMER1, 32'h0100);
    repeat (3) u_scc_pin_model.pulse_cnt(1);
    repeat (6) @(posedge pclk);
    rd(OFF_TIMER1, 32'h0103, "ext counted");
    rd(OFF_STATUS, 32'h0, "mode2 once");
  endtask : t_clock_src
  // ==========================================================
  // main sequence
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; aux_ovf = 1'b0;
    ce = 1'b1;
    n_errors = 0; checks = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_capture();
    t_compare();
    t_prescale();
    t_clock_src();
    tally_and_finish();
  end

  initial begin
    repeat (100000) @(posedge pclk);
    n_errors++;
    $display("[FAIL] %0t run limit", $time);
    tally_and_finish();
  end
endmodule : sixteen_channel_capture_compare_tb_top
